// File: hdl/adcc_pkg.sv
// Constants and types for the converter conversion control block
//
// How it works
// - Event pulse on every finished conversion, whatever the compare mode.
// - Gain stage in use adds exactly one converter clock of latency.
// - Single conversions through the gain stage are flagged as bad.
// - Gain select offers seven settings, 1x to 64x in powers of two.
// - Writes to absent options change nothing, like reserved locations.
// - Half gain encoding is ignored; previous gain setting stays.
// - Half supply reference encoding is ignored; previous reference stays.
// - Internal ground negative input encoding is ignored.
// - Channel scan register is absent: writes dropped, reads give zero.
// - Current limit bits are never stored.
// - Gain stage impedance mode bit is never stored.
package adcc_pkg;

    //------------------------------------------------------------
    // Widths and timing
    //------------------------------------------------------------
    localparam int          RES_W        = 12;
    localparam int          WORD_W       = 14;
    localparam int          FIFO_DEPTH   = 8;
    localparam int          WORD_SETTLE  = 12;   // Result not yet settled
    localparam int          WORD_SUSPECT = 13;   // Single gain conversion
    localparam logic [1:0]  ADC_DIV_LAST = 2'h3; // Converter clock = clk/4
    localparam logic [3:0]  BASE_LAT     = 4'h7; // Converter clocks
    localparam logic [3:0]  GAIN_EXTRA   = 4'h1;
    localparam logic [1:0]  SETTLE_N     = 2'h3;

    //------------------------------------------------------------
    // Field encodings and reset values
    //------------------------------------------------------------
    localparam logic [2:0]  GAIN_1X      = 3'h0;
    localparam logic [2:0]  GAIN_64X     = 3'h6;
    localparam logic [2:0]  GAIN_HALF    = 3'h7;
    localparam logic [2:0]  REF_HALF_VCC = 3'h2;
    localparam logic [2:0]  REF_RST      = 3'h0;
    localparam logic [2:0]  NEG_INT_GND  = 3'h7;
    localparam logic [2:0]  NEG_RST      = 3'h0;
    localparam logic [3:0]  POS_RST      = 4'h0;
    localparam logic [1:0]  CMP_COMPLETE = 2'h0;
    localparam logic [1:0]  CMP_BELOW    = 2'h1;
    localparam logic [1:0]  CMP_ABOVE    = 2'h3;
    localparam logic [11:0] THR_RST      = 12'h000;

    // Second control register readback bit positions
    localparam int          CB_FREERUN   = 0;
    localparam int          CB_SIGNED    = 1;
    localparam int          CB_GAINSTAGE = 2;
    localparam int          CB_CURLIM_LO = 5;
    localparam int          CB_GAIN_STAGE_IMPEDANCE_MODE   = 7;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONV,
        ST_PUSH
    } adcc_state_e;

endpackage

// File: hdl/adcc_stream_if.sv
// Valid/ready word stream between the block's own modules
`timescale 1ns/1ps
`default_nettype none
interface adcc_stream_if #(parameter int WIDTH = 14) ();
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: hdl/adcc_fifo.sv
// Result FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module adcc_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    // Fill and drain sides
    adcc_stream_if.snk  wr_s,
    adcc_stream_if.src  rd_s
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wptr_reg;
    logic [AW-1:0]    rptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    // Honest full and empty from the fill count
    assign wr_s.ready = (count_reg != (AW+1)'(DEPTH));
    assign rd_s.valid = (count_reg != '0);
    assign rd_s.data  = mem_reg[rptr_reg];
    assign push       = wr_s.valid && wr_s.ready;
    assign pop        = rd_s.valid && rd_s.ready;

    // Storage, one entry per index
    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_entry
            always_ff @(posedge clk_i) begin
                if (push && (wptr_reg == AW'(i))) begin
                    mem_reg[i] <= wr_s.data;
                end
            end
        end
    endgenerate

    // Pointers and count
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wptr_reg  <= '0;
            rptr_reg  <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wptr_reg <= wptr_reg + 1'b1;
            end
            if (pop) begin
                rptr_reg <= rptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: hdl/adcc_compare.sv
// Result compare against the threshold by compare mode
`timescale 1ns/1ps
`default_nettype none
module adcc_compare (
    // Operands
    input  wire logic [11:0] result_i,
    input  wire logic [11:0] threshold_i,
    input  wire logic        signed_i,
    input  wire logic [1:0]  compare_interrupt_mode_i,
    // Answer
    output logic             match_o
);
    logic below;
    logic above;

    // Signed or unsigned ordering of result and threshold
    always_comb begin
        if (signed_i) begin
            below = $signed(result_i) < $signed(threshold_i);
            above = $signed(result_i) > $signed(threshold_i);
        end else begin
            below = result_i < threshold_i;
            above = result_i > threshold_i;
        end
    end

    // Mode selects which relation raises the match
    always_comb begin
        case (compare_interrupt_mode_i)
            adcc_pkg::CMP_COMPLETE: match_o = 1'b1;
            adcc_pkg::CMP_BELOW:    match_o = below;
            adcc_pkg::CMP_ABOVE:    match_o = above;
            default:                match_o = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// File: hdl/adcc_control.sv
// Converter conversion control: configuration, sequencing, results
`timescale 1ns/1ps
`default_nettype none
module adcc_control (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Configuration write strobe and fields
    input  wire logic        cfg_write_i,
    input  wire logic [2:0]  gain_select_i,
    input  wire logic [2:0]  reference_select_i,
    input  wire logic [2:0]  negative_input_select_i,
    input  wire logic [3:0]  positive_input_select_i,
    input  wire logic        gain_stage_en_i,
    input  wire logic        free_run_i,
    input  wire logic        signed_mode_i,
    input  wire logic [1:0]  current_limit_select_i,
    input  wire logic        gain_stage_impedance_mode_i,
    input  wire logic [1:0]  compare_interrupt_mode_i,
    input  wire logic [11:0] threshold_i,
    // Absent channel scan register
    input  wire logic        scan_write_i,
    input  wire logic [7:0]  scan_wdata_i,
    output logic [7:0]       scan_rdata_o,
    // Conversion start and flag clear
    input  wire logic        start_i,
    input  wire logic        event_start_i,
    input  wire logic        cmp_flag_clear_i,
    // Readback and status
    output logic [2:0]       gain_select_o,
    output logic [2:0]       reference_control_register_o,
    output logic [2:0]       input_mux_control_register_o,
    output logic [7:0]       second_control_register_o,
    output logic             busy_o,
    output logic             cmp_flag_o,
    output logic             single_gain_hazard_o,
    // Event system
    output logic             conv_event_o,
    // Analog side
    output logic             sample_o,
    output logic [3:0]       channel_o,
    output logic [2:0]       analog_gain_o,
    output logic [2:0]       analog_reference_o,
    input  wire logic [11:0] analog_value_i,
    // Result stream
    output logic             result_valid_o,
    input  wire logic        result_ready_i,
    output logic [13:0]      result_data_o
);
    //------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------
    adcc_pkg::adcc_state_e state_reg;
    logic [2:0]  gain_reg;
    logic [2:0]  reference_select_reg;
    logic [2:0]  negative_input_select_reg;
    logic [3:0]  positive_input_reg;
    logic        gain_stage_reg;
    logic        free_run_reg;
    logic        signed_reg;
    logic [1:0]  compare_interrupt_mode_reg;
    logic [11:0] threshold_reg;
    logic [1:0]  div_reg;
    logic [3:0]  lat_reg;
    logic [3:0]  lat_target;
    logic        adc_tick;
    logic        single_reg;
    logic        conv_gain_reg;
    logic [1:0]  settle_reg;
    logic [13:0] word_reg;
    logic        sample_reg;
    logic        event_reg;
    logic        cmp_flag_reg;
    logic        hazard_reg;
    logic        match;
    logic        start_req;
    logic        conv_done;
    logic        push_done;
    logic        chan_change;

    adcc_stream_if #(.WIDTH(adcc_pkg::WORD_W)) in_s ();
    adcc_stream_if #(.WIDTH(adcc_pkg::WORD_W)) out_s ();

    //------------------------------------------------------------
    // Configuration storage
    //------------------------------------------------------------

    // Gain setting; encodings above the seven legal ones are dropped
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            gain_reg <= adcc_pkg::GAIN_1X;
        end else if (cfg_write_i && (gain_select_i <= adcc_pkg::GAIN_64X)) begin
            gain_reg <= gain_select_i;
        end
    end

    // Reference choice without the half supply option
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reference_select_reg <= adcc_pkg::REF_RST;
        end else if (cfg_write_i &&
                     (reference_select_i != adcc_pkg::REF_HALF_VCC)) begin
            reference_select_reg <= reference_select_i;
        end
    end

    // Negative input choice without internal ground
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            negative_input_select_reg <= adcc_pkg::NEG_RST;
        end else if (cfg_write_i &&
                     (negative_input_select_i != adcc_pkg::NEG_INT_GND)) begin
            negative_input_select_reg <= negative_input_select_i;
        end
    end

    // Remaining mode bits; current limit and impedance mode never stored
    // absent bits dropped
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            positive_input_reg         <= adcc_pkg::POS_RST;
            gain_stage_reg             <= 1'b0;
            free_run_reg               <= 1'b0;
            signed_reg                 <= 1'b0;
            compare_interrupt_mode_reg <= adcc_pkg::CMP_COMPLETE;
            threshold_reg              <= adcc_pkg::THR_RST;
        end else if (cfg_write_i) begin
            positive_input_reg         <= positive_input_select_i;
            gain_stage_reg             <= gain_stage_en_i;
            free_run_reg               <= free_run_i;
            signed_reg                 <= signed_mode_i;
            compare_interrupt_mode_reg <= compare_interrupt_mode_i;
            threshold_reg              <= threshold_i;
        end
    end

    //------------------------------------------------------------
    // Readback
    //------------------------------------------------------------

    assign scan_rdata_o = 8'h00;
    always_comb begin
        second_control_register_o = 8'h00;
        second_control_register_o[adcc_pkg::CB_FREERUN]   = free_run_reg;
        second_control_register_o[adcc_pkg::CB_SIGNED]    = signed_reg;
        second_control_register_o[adcc_pkg::CB_GAINSTAGE] = gain_stage_reg;
    end
    assign gain_select_o                = gain_reg;
    assign reference_control_register_o = reference_select_reg;
    assign input_mux_control_register_o = negative_input_select_reg;
    assign channel_o                    = positive_input_reg;
    assign analog_gain_o                = gain_reg;
    assign analog_reference_o           = reference_select_reg;

    //------------------------------------------------------------
    // Converter clock and sequencing
    //------------------------------------------------------------

    // Free running divider giving the converter clock tick
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
        end
    end
    assign adc_tick = (div_reg == adcc_pkg::ADC_DIV_LAST);

    assign lat_target = conv_gain_reg ?
                        adcc_pkg::BASE_LAT + adcc_pkg::GAIN_EXTRA :
                        adcc_pkg::BASE_LAT;

    assign start_req = start_i || event_start_i || free_run_reg;
    assign conv_done = (state_reg == adcc_pkg::ST_CONV) && adc_tick &&
                       (lat_reg == lat_target - 4'h1);
    assign push_done = (state_reg == adcc_pkg::ST_PUSH) && in_s.ready;

    // Conversion state machine; a full FIFO holds it in the push state
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= adcc_pkg::ST_IDLE;
        end else begin
            case (state_reg)
                adcc_pkg::ST_IDLE: begin
                    if (start_req) begin
                        state_reg <= adcc_pkg::ST_CONV;
                    end
                end
                adcc_pkg::ST_CONV: begin
                    if (conv_done) begin
                        state_reg <= adcc_pkg::ST_PUSH;
                    end
                end
                adcc_pkg::ST_PUSH: begin
                    if (in_s.ready) begin
                        state_reg <= free_run_reg ? adcc_pkg::ST_CONV :
                                                    adcc_pkg::ST_IDLE;
                    end
                end
                default: state_reg <= adcc_pkg::ST_IDLE;
            endcase
        end
    end

    // Latency count in converter clocks, restarted at each sample
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            lat_reg <= 4'h0;
        end else if (state_reg != adcc_pkg::ST_CONV) begin
            lat_reg <= 4'h0;
        end else if (adc_tick) begin
            lat_reg <= lat_reg + 4'h1;
        end
    end

    // Sample pulse and per-conversion mode capture at each start
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sample_reg    <= 1'b0;
            single_reg    <= 1'b0;
            conv_gain_reg <= 1'b0;
        end else begin
            sample_reg <= ((state_reg == adcc_pkg::ST_IDLE) && start_req) ||
                          (push_done && free_run_reg);
            if (((state_reg == adcc_pkg::ST_IDLE) && start_req) ||
                push_done) begin
                single_reg    <= !free_run_reg;
                conv_gain_reg <= gain_stage_reg;
            end
        end
    end
    assign sample_o = sample_reg;
    assign busy_o   = (state_reg != adcc_pkg::ST_IDLE);

    //------------------------------------------------------------
    // Settling and results
    //------------------------------------------------------------

    assign chan_change = cfg_write_i && gain_stage_en_i &&
                         (positive_input_select_i != positive_input_reg);
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            settle_reg <= 2'h0;
        end else if (chan_change) begin
            settle_reg <= adcc_pkg::SETTLE_N;
        end else if (conv_done && (settle_reg != 2'h0)) begin
            settle_reg <= settle_reg - 2'h1;
        end
    end

    // Result word with settle and suspect tags
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            word_reg <= 14'h0000;
        end else if (conv_done) begin
            word_reg[adcc_pkg::RES_W-1:0]    <= analog_value_i;
            word_reg[adcc_pkg::WORD_SETTLE]  <= (settle_reg != 2'h0);
            word_reg[adcc_pkg::WORD_SUSPECT] <= single_reg && conv_gain_reg;
        end
    end

    adcc_compare u_compare (
        .result_i                 (analog_value_i),
        .threshold_i              (threshold_reg),
        .signed_i                 (signed_reg),
        .compare_interrupt_mode_i (compare_interrupt_mode_reg),
        .match_o                  (match)
    );

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            event_reg <= 1'b0;
        end else begin
            event_reg <= conv_done;
        end
    end
    assign conv_event_o = event_reg;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cmp_flag_reg <= 1'b0;
        end else if (conv_done && match) begin
            cmp_flag_reg <= 1'b1;
        end else if (cmp_flag_clear_i) begin
            cmp_flag_reg <= 1'b0;
        end
    end
    assign cmp_flag_o = cmp_flag_reg;

    // Sticky report of a single conversion through the gain stage
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            hazard_reg <= 1'b0;
        end else if (conv_done && single_reg && conv_gain_reg) begin
            hazard_reg <= 1'b1;
        end
    end
    assign single_gain_hazard_o = hazard_reg;

    //------------------------------------------------------------
    // Result FIFO
    //------------------------------------------------------------
    assign in_s.valid = (state_reg == adcc_pkg::ST_PUSH);
    assign in_s.data  = word_reg;

    adcc_fifo #(
        .WIDTH (adcc_pkg::WORD_W),
        .DEPTH (adcc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .wr_s    (in_s),
        .rd_s    (out_s)
    );

    assign result_valid_o = out_s.valid;
    assign result_data_o  = out_s.data;
    assign out_s.ready    = result_ready_i;
endmodule
`default_nettype wire

// File: sim/adcc_control_props.sv
// Assertions on the conversion control ports
`timescale 1ns/1ps
`default_nettype none
module adcc_control_props (
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    // Watched ports
    input wire logic       cfg_write_i,
    input wire logic [2:0] gain_select_i,
    input wire logic [2:0] reference_select_i,
    input wire logic [2:0] gain_select_o,
    input wire logic [2:0] reference_control_register_o,
    input wire logic [7:0] second_control_register_o,
    input wire logic [7:0] scan_rdata_o,
    input wire logic       sample_o,
    input wire logic       conv_event_o,
    input wire logic       single_gain_hazard_o
);
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Stored gain stage and free run bits
    wire logic gs = second_control_register_o[adcc_pkg::CB_GAINSTAGE];
    wire logic fr = second_control_register_o[adcc_pkg::CB_FREERUN];

    a_event_plain: assert property (
        sample_o && !gs |-> ##[25:28] conv_event_o) else $error("No event");
    a_event_gain: assert property (
        sample_o && gs |-> ##[29:32] conv_event_o) else $error("Gain lat");
    a_event_pulse: assert property (
        conv_event_o |=> !conv_event_o) else $error("Event too long");
    a_scan_zero: assert property (
        scan_rdata_o == 8'h00) else $error("Scan not zero");
    a_absent_bits: assert property (
        second_control_register_o[7:3] == 5'h00) else $error("Absent bit");
    a_half_gain: assert property (
        cfg_write_i && gain_select_i == adcc_pkg::GAIN_HALF
        |=> $stable(gain_select_o)) else $error("Half gain taken");
    a_gain_taken: assert property (
        cfg_write_i && gain_select_i != adcc_pkg::GAIN_HALF
        |=> gain_select_o == $past(gain_select_i)) else $error("Gain lost");
    a_half_ref: assert property (
        cfg_write_i && reference_select_i == adcc_pkg::REF_HALF_VCC
        |=> $stable(reference_control_register_o)) else $error("Ref taken");
    a_single_hazard: assert property (
        sample_o && gs && !fr |-> ##[1:34] single_gain_hazard_o)
        else $error("No hazard");

    c_free_gain: cover property (sample_o && gs && fr);
    c_single_gain: cover property (sample_o && gs && !fr);
    c_half_gain: cover property (cfg_write_i && gain_select_i == 3'h7);
endmodule
bind adcc_control adcc_control_props i_adcc_control_props (
    .clk_i, .rst_n_i, .cfg_write_i, .gain_select_i, .reference_select_i,
    .gain_select_o, .reference_control_register_o,
    .second_control_register_o, .scan_rdata_o, .sample_o, .conv_event_o,
    .single_gain_hazard_o);
`default_nettype wire

// File: sim/adcc_analog_model.sv
// Analog input model: holds a known level per conversion
`timescale 1ns/1ps
`default_nettype none
module adcc_analog_model (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Converter side
    input  wire logic        sample_i,
    input  wire logic        done_i,
    input  wire logic [3:0]  channel_i,
    output logic      [11:0] value_o
);
    logic [7:0]  count_reg;
    logic        hold_reg;
    logic [11:0] level_reg;
    // Level is channel and count while held, toggles otherwise
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            count_reg <= 8'h00;
            hold_reg  <= 1'b0;
            level_reg <= 12'hA5A;
        end else if (sample_i) begin
            count_reg <= count_reg + 8'h01;
            hold_reg  <= 1'b1;
            level_reg <= {channel_i, count_reg};
        end else begin
            if (done_i) hold_reg <= 1'b0;
            if (!hold_reg) level_reg <= ~level_reg;
        end
    end
    assign value_o = level_reg;
endmodule
`default_nettype wire

// File: sim/adcc_control_bench.sv
// Self-checking bench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module adcc_control_bench;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        cfg_write_i = 1'b0;
    logic        scan_write_i = 1'b0;
    logic        start_i = 1'b0;
    logic        event_start_i = 1'b0;
    logic        cmp_flag_clear_i = 1'b0;
    logic        result_ready_i = 1'b0;
    logic        stall = 1'b0;
    logic [32:0] cfg_bus = '0;
    logic [32:0] v;
    logic [7:0]  scan_wdata_i = 8'h00;
    logic [7:0]  scan_rdata_o, second_control_register_o, samples, e_cb;
    logic [11:0] analog_value_i;
    logic [2:0]  gain_select_o, reference_control_register_o, e_gain;
    logic [2:0]  input_mux_control_register_o, analog_gain_o, e_ref;
    logic [2:0]  analog_reference_o, e_neg;
    logic [3:0]  channel_o, e_pos;
    logic [13:0] result_data_o;
    logic        busy_o, cmp_flag_o, single_gain_hazard_o, conv_event_o;
    logic        sample_o, result_valid_o;
    logic [13:0] exp_q[$], exp_w;
    int          failures = 0, comparisons = 0, events = 0, ev0, settle;
    int          cycles = 0, seed = 85;

    adcc_control i_adcc_control (
        .gain_select_i              (cfg_bus[32:30]),
        .reference_select_i         (cfg_bus[29:27]),
        .negative_input_select_i    (cfg_bus[26:24]),
        .positive_input_select_i    (cfg_bus[23:20]),
        .gain_stage_en_i            (cfg_bus[19]),
        .free_run_i                 (cfg_bus[18]),
        .signed_mode_i              (cfg_bus[17]),
        .current_limit_select_i     (cfg_bus[16:15]),
        .gain_stage_impedance_mode_i(cfg_bus[14]),
        .compare_interrupt_mode_i   (cfg_bus[13:12]),
        .threshold_i                (cfg_bus[11:0]),
        .*
    );
    adcc_analog_model i_adcc_analog_model (
        .clk_i, .rst_n_i, .sample_i(sample_o), .done_i(conv_event_o),
        .channel_i(channel_o), .value_o(analog_value_i));

    // Clock of 100 ns
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    // Far side takes words at random unless stalled
    always @(negedge clk_i) begin
        result_ready_i <= !stall && ($random(seed) % 3 != 0);
    end
    // Expected words, stream compare, events and watchdog
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            wrap_up();
        end
        if (conv_event_o === 1'b1) events++;
        if (rst_n_i && sample_o === 1'b1) begin
            exp_q.push_back({e_cb[2] && !e_cb[0], settle > 0, e_pos, samples});
            settle = (settle > 0) ? settle - 1 : 0;
            samples++;
        end
        if (rst_n_i && result_valid_o === 1'b1 && result_ready_i) begin
            exp_w = exp_q.pop_front();
            `CHK(result_data_o, exp_w)
        end
    end

    task automatic check_cfg;
        `CHK(gain_select_o, e_gain)
        `CHK(analog_gain_o, e_gain)
        `CHK(reference_control_register_o, e_ref)
        `CHK(analog_reference_o, e_ref)
        `CHK(input_mux_control_register_o, e_neg)
        `CHK(second_control_register_o, e_cb)
        `CHK(channel_o, e_pos)
        `CHK(scan_rdata_o, 8'h00)
    endtask

    task automatic do_reset;
        @(negedge clk_i);
        rst_n_i = 1'b0;
        repeat (6) @(negedge clk_i);
        rst_n_i = 1'b1;
        {e_gain, e_ref, e_neg, e_pos, e_cb, samples} = '0;
        settle = 0;
        exp_q.delete();
        check_cfg();
        `CHK({busy_o, cmp_flag_o, single_gain_hazard_o}, 3'h0)
    endtask

    task automatic cfg(input logic [32:0] w);
        @(negedge clk_i);
        cfg_bus = w;
        cfg_write_i = 1'b1;
        if (w[32:30] != adcc_pkg::GAIN_HALF) e_gain = w[32:30];
        if (w[29:27] != adcc_pkg::REF_HALF_VCC) e_ref = w[29:27];
        if (w[26:24] != adcc_pkg::NEG_INT_GND) e_neg = w[26:24];
        if (w[19] && w[23:20] != e_pos) settle = 3;
        e_pos = w[23:20];
        e_cb = {5'h00, w[19], w[17], w[18]};
        @(negedge clk_i);
        cfg_write_i = 1'b0;
        check_cfg();
    endtask

    task automatic pulse(input logic ev);
        @(negedge clk_i);
        start_i = !ev;
        event_start_i = ev;
        @(negedge clk_i);
        start_i = 1'b0;
        event_start_i = 1'b0;
    endtask

    task automatic wait_idle;
        for (int n = 0; n < 200 && busy_o !== 1'b0; n++) @(negedge clk_i);
        `CHK(busy_o, 1'b0)
    endtask

    task automatic drain;
        for (int n = 0; n < 300 && exp_q.size() != 0; n++) @(negedge clk_i);
        `CHK(exp_q.size(), 0)
    endtask

    task automatic wrap_up;
        if (failures == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        do_reset();
        // Random writes, absent encodings and scan writes among them
        for (int i = 0; i < 24; i++) begin
            v = 33'({$random(seed), $random(seed)});
            v[18] = 1'b0;
            if (i % 4 == 1) v[32:24] = 9'h1D7;
            cfg(v);
            @(negedge clk_i);
            scan_write_i = 1'b1;
            scan_wdata_i = v[7:0];
            @(negedge clk_i);
            scan_write_i = 1'b0;
            check_cfg();
        end
        do_reset();
        // signed mode, one conversion per compare mode
        for (int m = 0; m < 4; m++) begin
            cfg({13'h0001, 3'b001, 3'h0, 2'(m), 12'h7F0});
            ev0 = events;
            pulse(m[0]);
            wait_idle();
            `CHK(events - ev0, 1)
            `CHK(cmp_flag_o, 1'(m < 2))
            @(negedge clk_i);
            cmp_flag_clear_i = 1'b1;
            @(negedge clk_i);
            cmp_flag_clear_i = 1'b0;
            `CHK(cmp_flag_o, 1'b0)
        end
        // Single conversion through the gain stage, absent bits set
        cfg({3'h6, 6'h00, 4'h5, 3'b101, 3'h7, 2'h0, 12'h000});
        pulse(1'b1);
        wait_idle();
        `CHK(single_gain_hazard_o, 1'b1)
        drain();
        // free run through the gain stage, FIFO filled
        ev0 = events;
        stall = 1'b1;
        cfg({3'h3, 6'h00, 4'h9, 3'b111, 3'h0, 2'h1, 12'h000});
        repeat (400) @(negedge clk_i);
        `CHK(events - ev0, 9)
        `CHK(exp_q.size(), 9)
        stall = 1'b0;
        repeat (150) @(negedge clk_i);
        while (sample_o !== 1'b1) @(negedge clk_i);
        cfg({3'h3, 6'h00, 4'h9, 3'b101, 3'h0, 2'h1, 12'h000});
        wait_idle();
        drain();
        wrap_up();
    end
endmodule
`default_nettype wire
